// ### verilog/opmode_clk_pkg.sv
// Constants, register map and types of the operating-mode clock controller.
// Assumes a 100 MHz APB clock that also stands in for the main oscillator.
package opmode_clk_pkg;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_POWER_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CLK_SOURCE = 8'h04;
	localparam logic [7:0] OFS_BUS_DIVIDER = 8'h08;
	localparam logic [7:0] OFS_CLK_ENABLE = 8'h0C;
	localparam logic [7:0] OFS_START_POLARITY = 8'h10;
	localparam logic [7:0] OFS_START_ENABLE = 8'h14;
	localparam logic [7:0] OFS_START_RAW = 8'h18;
	localparam logic [7:0] OFS_START_STATUS = 8'h1C;
	localparam logic [7:0] OFS_MODE_STATUS = 8'h20;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int PWR_STOP_BIT = 0;
	localparam int PWR_HC_SW_BIT = 1;
	localparam int PWR_RUN_SEL_BIT = 2;
	localparam int PWR_HC_VAL_BIT = 5;
	localparam int SRC_RTC_SEL_BIT = 0;
	localparam int SRC_MAIN_PLL_BIT = 1;
	localparam int SRC_USB_PLL_BIT = 2;
	localparam int SRC_RTC_PLL_BIT = 3;
	localparam int DIV_AHB_LSB = 0;
	localparam int DIV_PERIPH_LSB = 2;
	localparam int EN_USB_BUS_BIT = 0;
	localparam int EN_USB_48M_BIT = 1;
	localparam int EN_DDR_BIT = 2;
	localparam int EN_DDR_DIV2_BIT = 3;
	localparam int EN_SD_DIV_LSB = 4;

	// ****************************************
	// Reset values and clock figures
	// ****************************************
	localparam logic RTC_PLL_RUN_RST = 1'b1;
	localparam logic [1:0] AHB_DIV_RST = 2'h0;
	localparam logic [4:0] PERIPH_DIV_RST = 5'h00;
	localparam logic [3:0] SD_DIV_RST = 4'h0;
	localparam int USB_PREDIV = 13;
	localparam int USB_PLL_MULT = 48;
	localparam int AHB_MAX_MHZ = 104;
	localparam int CPU_MAX_MHZ = 208;
	localparam int SD_DIV_MAX = 15;

	typedef enum logic [3:0] {
		MODE_DIRECT = 4'b0001,
		MODE_RUN = 4'b0010,
		MODE_STOP = 4'b0100,
		MODE_SWITCH = 4'b1000
	} op_mode_t;

endpackage

// ### verilog/opmode_clk_ctrl.sv
// Operating-mode clock controller: run, direct run and stop modes, clock gates,
// derived clock strobes, start controller and core-voltage request.
// Assumes an APB master on pclk; clocks are produced as gate and strobe levels.
`timescale 1ns/100ps
module opmode_clk_ctrl import opmode_clk_pkg::*; #(
	parameter int NUM_START = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_START-1:0] start_src,
	input wire logic main_pll_locked,
	input wire logic usb_pll_locked,
	output logic cpu_clock_gate,
	output logic ahb_clock_gate,
	output logic peripheral_clock_gate,
	output logic clk_src_pll,
	output logic system_base_clock_gate,
	output logic system_base_src_rtc,
	output logic [1:0] ahb_div_sel,
	output logic [4:0] periph_div_sel,
	output logic main_pll_power,
	output logic usb_pll_power,
	output logic rtc_multiplier_pll_run,
	output logic usb_pll_ref,
	output logic usb_48m_clock_gate,
	output logic usb_bus_clock_gate,
	output logic ddr_memory_clock_gate,
	output logic ddr_div2,
	output logic sd_card_clock,
	output logic core_voltage_high_request,
	output logic [3:0] op_mode
);

	typedef struct packed {
		op_mode_t mode;
		logic to_run;
		logic stop_pend;
		logic pwr_stop;
		logic pwr_hc_sw;
		logic pwr_run_sel;
		logic pwr_hc_val;
		logic src_rtc;
		logic main_pll_on;
		logic usb_pll_on;
		logic rtc_pll_on;
		logic [1:0] ahb_div;
		logic [4:0] periph_div;
		logic en_usb_bus;
		logic en_usb_48m;
		logic en_ddr;
		logic ddr_div2;
		logic [3:0] sd_div;
		logic [3:0] sd_cnt;
		logic [3:0] usb_cnt;
		logic [NUM_START-1:0] start_pol;
		logic [NUM_START-1:0] start_en;
		logic [NUM_START-1:0] start_raw;
		logic [NUM_START-1:0] start_lvl;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic cpu_gate;
		logic ahb_gate;
		logic periph_gate;
		logic sel_pll;
		logic usb_ref;
		logic usb_48m_gate;
		logic usb_bus_gate;
		logic ddr_gate;
		logic sd_clk;
		logic hc_req;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	// ****************************************
	// Start source edge detection
	// ****************************************
	logic [NUM_START-1:0] start_lvl;
	logic [NUM_START-1:0] start_edge;
	logic [NUM_START-1:0] start_masked;
	logic start_activated;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_START; gi++) begin : g_start
			assign start_lvl[gi] = st_ff.start_pol[gi] ? ~start_src[gi] : start_src[gi];
			assign start_edge[gi] = start_lvl[gi] & ~st_ff.start_lvl[gi];
			assign start_masked[gi] = st_ff.start_raw[gi] & st_ff.start_en[gi];
		end
	endgenerate

	assign start_activated = |start_masked;

	// ****************************************
	// APB decode
	// ****************************************
	logic wr_en;
	logic setup;
	logic act_now;
	logic addr_ok;
	logic [31:0] rd_mux;

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & st_ff.pready;
	// Event in the write cycle counts as active before the write
	assign act_now = start_activated | (|(start_edge & st_ff.start_en));

	always_comb begin
		rd_mux = 32'h0000_0000;
		addr_ok = 1'b1;
		unique case (paddr)
			OFS_POWER_CONTROL: begin
				rd_mux[PWR_STOP_BIT] = st_ff.pwr_stop;
				rd_mux[PWR_HC_SW_BIT] = st_ff.pwr_hc_sw;
				rd_mux[PWR_RUN_SEL_BIT] = st_ff.pwr_run_sel;
				rd_mux[PWR_HC_VAL_BIT] = st_ff.pwr_hc_val;
			end
			OFS_CLK_SOURCE: begin
				rd_mux[SRC_RTC_SEL_BIT] = st_ff.src_rtc;
				rd_mux[SRC_MAIN_PLL_BIT] = st_ff.main_pll_on;
				rd_mux[SRC_USB_PLL_BIT] = st_ff.usb_pll_on;
				rd_mux[SRC_RTC_PLL_BIT] = st_ff.rtc_pll_on;
			end
			OFS_BUS_DIVIDER: begin
				rd_mux[DIV_AHB_LSB +: 2] = st_ff.ahb_div;
				rd_mux[DIV_PERIPH_LSB +: 5] = st_ff.periph_div;
			end
			OFS_CLK_ENABLE: begin
				rd_mux[EN_USB_BUS_BIT] = st_ff.en_usb_bus;
				rd_mux[EN_USB_48M_BIT] = st_ff.en_usb_48m;
				rd_mux[EN_DDR_BIT] = st_ff.en_ddr;
				rd_mux[EN_DDR_DIV2_BIT] = st_ff.ddr_div2;
				rd_mux[EN_SD_DIV_LSB +: 4] = st_ff.sd_div;
			end
			OFS_START_POLARITY: rd_mux[NUM_START-1:0] = st_ff.start_pol;
			OFS_START_ENABLE: rd_mux[NUM_START-1:0] = st_ff.start_en;
			OFS_START_RAW: rd_mux[NUM_START-1:0] = st_ff.start_raw;
			OFS_START_STATUS: rd_mux[NUM_START-1:0] = start_masked;
			OFS_MODE_STATUS: begin
				rd_mux[3:0] = st_ff.mode;
				rd_mux[4] = main_pll_locked;
				rd_mux[5] = usb_pll_locked;
				rd_mux[6] = start_activated;
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pready = setup;
		nxt_st.prdata = setup ? rd_mux : 32'h0000_0000;
		nxt_st.pslverr = setup & ~addr_ok;
		nxt_st.start_lvl = start_lvl;

		if (wr_en) begin
			unique case (paddr)
				OFS_POWER_CONTROL: begin
					nxt_st.pwr_stop = pwdata[PWR_STOP_BIT];
					nxt_st.pwr_hc_sw = pwdata[PWR_HC_SW_BIT];
					nxt_st.pwr_run_sel = pwdata[PWR_RUN_SEL_BIT];
					nxt_st.pwr_hc_val = pwdata[PWR_HC_VAL_BIT];
					nxt_st.stop_pend = pwdata[PWR_STOP_BIT] & ~act_now;
				end
				OFS_CLK_SOURCE: begin
					nxt_st.src_rtc = pwdata[SRC_RTC_SEL_BIT];
					nxt_st.main_pll_on = pwdata[SRC_MAIN_PLL_BIT];
					nxt_st.usb_pll_on = pwdata[SRC_USB_PLL_BIT];
					nxt_st.rtc_pll_on = pwdata[SRC_RTC_PLL_BIT];
				end
				OFS_BUS_DIVIDER: begin
					nxt_st.ahb_div = pwdata[DIV_AHB_LSB +: 2];
					nxt_st.periph_div = pwdata[DIV_PERIPH_LSB +: 5];
				end
				OFS_CLK_ENABLE: begin
					nxt_st.en_usb_bus = pwdata[EN_USB_BUS_BIT];
					nxt_st.en_usb_48m = pwdata[EN_USB_48M_BIT];
					nxt_st.en_ddr = pwdata[EN_DDR_BIT];
					nxt_st.ddr_div2 = pwdata[EN_DDR_DIV2_BIT];
					nxt_st.sd_div = pwdata[EN_SD_DIV_LSB +: 4];
					nxt_st.sd_cnt = 4'h0;
				end
				OFS_START_POLARITY: nxt_st.start_pol = pwdata[NUM_START-1:0];
				OFS_START_ENABLE: nxt_st.start_en = pwdata[NUM_START-1:0];
				OFS_START_RAW: nxt_st.start_raw = st_ff.start_raw & ~pwdata[NUM_START-1:0];
				default: ;
			endcase
		end
		// New start events win over a clear in the same cycle
		nxt_st.start_raw = nxt_st.start_raw | start_edge;

		// Mode sequencing; every clk_src_pll change passes a gap cycle
		unique case (st_ff.mode)
			MODE_DIRECT: begin
				if (st_ff.stop_pend) begin
					nxt_st.mode = MODE_STOP;
					nxt_st.stop_pend = 1'b0;
				end else if (st_ff.pwr_run_sel & st_ff.main_pll_on & main_pll_locked) begin
					nxt_st.mode = MODE_SWITCH;
					nxt_st.to_run = 1'b1;
				end
			end
			MODE_RUN: begin
				if (st_ff.stop_pend | ~st_ff.pwr_run_sel | ~st_ff.main_pll_on | ~main_pll_locked) begin
					nxt_st.mode = MODE_SWITCH;
					nxt_st.to_run = 1'b0;
				end
			end
			MODE_SWITCH: begin
				nxt_st.mode = st_ff.to_run ? MODE_RUN : MODE_DIRECT;
			end
			MODE_STOP: begin
				if (start_activated) begin
					nxt_st.mode = MODE_DIRECT;
					nxt_st.pwr_stop = 1'b0;
				end
			end
		endcase

		// Source select flips on leaving the gap; the DDR gate opens with it, the CPU, AHB, peripheral, base and USB bus gates reopen one cycle later
		nxt_st.sel_pll = (nxt_st.mode == MODE_RUN)
				| ((nxt_st.mode == MODE_SWITCH) & st_ff.sel_pll);
		nxt_st.cpu_gate = ((nxt_st.mode == MODE_RUN) | (nxt_st.mode == MODE_DIRECT))
				& (st_ff.mode != MODE_SWITCH);
		nxt_st.ahb_gate = nxt_st.cpu_gate;
		nxt_st.periph_gate = nxt_st.cpu_gate;
		nxt_st.usb_bus_gate = nxt_st.ahb_gate & nxt_st.en_usb_bus;
		nxt_st.ddr_gate = (nxt_st.mode == MODE_RUN) & nxt_st.en_ddr;
		nxt_st.hc_req = nxt_st.pwr_hc_sw ? nxt_st.pwr_hc_val
				: (nxt_st.mode == MODE_STOP);

		// USB path runs from the oscillator only, whatever the mode
		nxt_st.usb_ref = 1'b0;
		if (st_ff.usb_pll_on) begin
			if (st_ff.usb_cnt == 4'(USB_PREDIV - 1)) begin
				nxt_st.usb_cnt = 4'h0;
				nxt_st.usb_ref = 1'b1;
			end else begin
				nxt_st.usb_cnt = st_ff.usb_cnt + 4'h1;
			end
		end else begin
			nxt_st.usb_cnt = 4'h0;
		end
		nxt_st.usb_48m_gate = st_ff.usb_pll_on & usb_pll_locked & st_ff.en_usb_48m;

		// SD strobe every sd_div CPU cycles; zero keeps it stopped
		nxt_st.sd_clk = 1'b0;
		if (st_ff.cpu_gate && st_ff.sd_div != 4'h0 && !(wr_en && paddr == OFS_CLK_ENABLE)) begin
			if (st_ff.sd_cnt >= st_ff.sd_div - 4'h1) begin
				nxt_st.sd_cnt = 4'h0;
				nxt_st.sd_clk = 1'b1;
			end else begin
				nxt_st.sd_cnt = st_ff.sd_cnt + 4'h1;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.mode <= MODE_DIRECT;
			st_ff.rtc_pll_on <= RTC_PLL_RUN_RST;
			st_ff.ahb_div <= AHB_DIV_RST;
			st_ff.periph_div <= PERIPH_DIV_RST;
			st_ff.sd_div <= SD_DIV_RST;
			st_ff.cpu_gate <= 1'b1;
			st_ff.ahb_gate <= 1'b1;
			st_ff.periph_gate <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign cpu_clock_gate = st_ff.cpu_gate;
	assign ahb_clock_gate = st_ff.ahb_gate;
	assign peripheral_clock_gate = st_ff.periph_gate;
	assign clk_src_pll = st_ff.sel_pll;
	assign system_base_clock_gate = st_ff.cpu_gate;
	assign system_base_src_rtc = st_ff.src_rtc;
	assign ahb_div_sel = st_ff.ahb_div;
	assign periph_div_sel = st_ff.periph_div;
	assign main_pll_power = st_ff.main_pll_on;
	assign usb_pll_power = st_ff.usb_pll_on;
	assign rtc_multiplier_pll_run = st_ff.rtc_pll_on;
	assign usb_pll_ref = st_ff.usb_ref;
	assign usb_48m_clock_gate = st_ff.usb_48m_gate;
	assign usb_bus_clock_gate = st_ff.usb_bus_gate;
	assign ddr_memory_clock_gate = st_ff.ddr_gate;
	assign ddr_div2 = st_ff.ddr_div2;
	assign sd_card_clock = st_ff.sd_clk;
	assign core_voltage_high_request = st_ff.hc_req;
	assign op_mode = st_ff.mode;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_stop_write;
		wr_en && paddr == OFS_POWER_CONTROL && pwdata[PWR_STOP_BIT] && !act_now
			&& st_ff.mode == MODE_DIRECT;
	endsequence

	sequence s_stop_exit;
		st_ff.mode == MODE_STOP && start_activated;
	endsequence

	a_stop_entry: assert property (s_stop_write |=> ##1 st_ff.mode == MODE_STOP)
		else $error("stop mode not entered after stop write");
	a_stop_blocked: assert property (wr_en && paddr == OFS_POWER_CONTROL
			&& pwdata[PWR_STOP_BIT] && act_now |=> st_ff.pwr_stop && !st_ff.stop_pend)
		else $error("stop entered or bit cleared despite active start");
	a_stop_exit: assert property (s_stop_exit |=> st_ff.mode == MODE_DIRECT
			&& !st_ff.pwr_stop && st_ff.cpu_gate)
		else $error("stop exit did not restore clocks or clear bit");
	a_stop_gates: assert property (st_ff.mode == MODE_STOP |-> !cpu_clock_gate
			&& !ahb_clock_gate && !peripheral_clock_gate)
		else $error("clock running in stop mode");
	a_volt_request: assert property (!st_ff.pwr_hc_sw |->
			core_voltage_high_request == (st_ff.mode == MODE_STOP))
		else $error("voltage request does not follow mode");
	a_ddr_direct: assert property (st_ff.mode != MODE_RUN |-> !ddr_memory_clock_gate)
		else $error("ddr clock outside run mode");
	a_switch_gap: assert property ($changed(clk_src_pll) |-> !cpu_clock_gate
			&& !$past(cpu_clock_gate))
		else $error("clock source changed while gated on");
	a_usb_ref_period: assert property (usb_pll_ref && st_ff.usb_pll_on |=> !usb_pll_ref [*8]
			##1 !usb_pll_ref [*4])
		else $error("usb reference strobe period wrong");
	a_raw_set_wins: assert property (|start_edge |=> (st_ff.start_raw & $past(start_edge))
			== $past(start_edge))
		else $error("start event lost");
	a_usb_bus_gate: assert property (usb_bus_clock_gate |-> ahb_clock_gate && st_ff.en_usb_bus)
		else $error("usb bus clock without enable");

endmodule

// ### tb/opmode_partner.sv
// Far-side model: PLL lock outputs and wake-up event sources.
// Assumes the bench sets source levels through wake_lvl on pclk edges.
`timescale 1ns/100ps
module opmode_partner #(
	parameter int NUM_START = 8,
	parameter int LOCK_DLY = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic main_pll_power,
	input wire logic usb_pll_power,
	input wire logic [NUM_START-1:0] wake_lvl,
	output logic main_pll_locked,
	output logic usb_pll_locked,
	output logic [NUM_START-1:0] start_src
);
	int main_cnt;
	int usb_cnt;

	// Lock only after power has been stable; lost at once on power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_cnt <= 0;
			usb_cnt <= 0;
			start_src <= '0;
		end else begin
			main_cnt <= main_pll_power ? main_cnt + (main_cnt < LOCK_DLY) : 0;
			usb_cnt <= usb_pll_power ? usb_cnt + (usb_cnt < LOCK_DLY) : 0;
			start_src <= wake_lvl;
		end
	end
	assign main_pll_locked = main_pll_power && main_cnt >= LOCK_DLY;
	assign usb_pll_locked = usb_pll_power && usb_cnt >= LOCK_DLY;
endmodule

// ### tb/tb_opmode_clk_ctrl.sv
// Self-checking bench for the operating-mode clock controller.
// Assumes the partner model supplies PLL locks and wake-up sources.
`timescale 1ns/100ps
module tb_opmode_clk_ctrl import opmode_clk_pkg::*;;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, err;
	logic main_pll_locked, usb_pll_locked, cpu_clock_gate, ahb_clock_gate;
	logic peripheral_clock_gate, clk_src_pll, system_base_clock_gate, system_base_src_rtc;
	logic main_pll_power, usb_pll_power, rtc_multiplier_pll_run, usb_pll_ref;
	logic usb_48m_clock_gate, usb_bus_clock_gate, ddr_memory_clock_gate, ddr_div2;
	logic sd_card_clock, core_voltage_high_request;
	logic [7:0] paddr, start_src, wake_lvl;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] ahb_div_sel;
	logic [4:0] periph_div_sel;
	logic [3:0] op_mode;
	logic [2:0] flags;
	logic [11:0] vec;
	int n_mismatch = 0;
	int checks_done = 0;
	int sd_divs[3] = '{1, 6, 15};

	assign flags = {usb_48m_clock_gate, usb_pll_ref, sd_card_clock};
	assign vec = {cpu_clock_gate, ahb_clock_gate, peripheral_clock_gate, system_base_clock_gate,
		clk_src_pll, rtc_multiplier_pll_run, main_pll_power, usb_pll_power,
		usb_48m_clock_gate, usb_bus_clock_gate, ddr_memory_clock_gate, core_voltage_high_request};

	always #5 pclk = ~pclk;

	opmode_clk_ctrl #(.NUM_START(8)) opmode_clk_ctrl_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.start_src(start_src), .main_pll_locked(main_pll_locked),
		.usb_pll_locked(usb_pll_locked), .cpu_clock_gate(cpu_clock_gate),
		.ahb_clock_gate(ahb_clock_gate), .peripheral_clock_gate(peripheral_clock_gate),
		.clk_src_pll(clk_src_pll), .system_base_clock_gate(system_base_clock_gate),
		.system_base_src_rtc(system_base_src_rtc), .ahb_div_sel(ahb_div_sel),
		.periph_div_sel(periph_div_sel), .main_pll_power(main_pll_power),
		.usb_pll_power(usb_pll_power), .rtc_multiplier_pll_run(rtc_multiplier_pll_run),
		.usb_pll_ref(usb_pll_ref), .usb_48m_clock_gate(usb_48m_clock_gate),
		.usb_bus_clock_gate(usb_bus_clock_gate), .ddr_memory_clock_gate(ddr_memory_clock_gate),
		.ddr_div2(ddr_div2), .sd_card_clock(sd_card_clock),
		.core_voltage_high_request(core_voltage_high_request), .op_mode(op_mode));

	opmode_partner #(.NUM_START(8), .LOCK_DLY(20)) opmode_partner_i (
		.pclk(pclk), .presetn(presetn), .main_pll_power(main_pll_power),
		.usb_pll_power(usb_pll_power), .wake_lvl(wake_lvl), .main_pll_locked(main_pll_locked),
		.usb_pll_locked(usb_pll_locked), .start_src(start_src));

	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic settle;
		repeat (2) @(posedge pclk);
	endtask

	task automatic wait_mode(input logic [3:0] m);
		int i;
		for (i = 0; i < 60 && op_mode !== m; i++) begin
			@(posedge pclk);
		end
		chk(op_mode, m);
	endtask

	task automatic wait_bit(input int idx);
		int i;
		for (i = 0; i < 60 && flags[idx] !== 1'b1; i++) begin
			@(posedge pclk);
		end
		chk(flags[idx], 1'b1);
	endtask

	// Second interval is measured so a divider change settles first
	task automatic gap_chk(input int idx, input int exp);
		int n;
		wait_bit(idx);
		repeat (2) begin
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (flags[idx] !== 1'b1 && n < 40);
		end
		chk(n, exp);
	endtask

	task automatic finish_test;
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		wake_lvl = 8'h00;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		settle;
		chk(op_mode, MODE_DIRECT);
		chk(vec, 12'hF40);
		apb(0, OFS_CLK_SOURCE, 32'h0);
		chk(rd, 32'h8);
		apb(0, 8'h40, 32'h0);
		chk(err, 1'b1);
		apb(1, OFS_CLK_ENABLE, 32'h7);
		settle;
		chk(vec[2:1], 2'b10);
		foreach (sd_divs[k]) begin
			apb(1, OFS_CLK_ENABLE, (sd_divs[k] << 4) | 7);
			gap_chk(0, sd_divs[k]);
		end
		apb(1, OFS_CLK_SOURCE, 32'hE);
		wait_bit(2);
		gap_chk(1, USB_PREDIV);
		apb(1, OFS_BUS_DIVIDER, 32'h0);
		apb(1, OFS_POWER_CONTROL, 32'h4);
		wait_mode(MODE_SWITCH);
		chk(vec[11:9], 3'b000);
		wait_mode(MODE_RUN);
		chk(vec[11:7], 5'h01);
		settle;
		chk({vec[11:7], vec[1]}, 6'h3F);
		apb(1, OFS_CLK_ENABLE, 32'hF);
		settle;
		chk(ddr_div2, 1'b1);
		for (int d = 0; d < 3; d++) begin
			apb(1, OFS_BUS_DIVIDER, (3 << 2) | d);
			settle;
			chk({periph_div_sel, ahb_div_sel}, (3 << 2) | d);
		end
		apb(1, OFS_POWER_CONTROL, 32'h0);
		wait_mode(MODE_DIRECT);
		settle;
		chk({vec[11:7], vec[1:0]}, 7'h78);
		apb(1, OFS_START_ENABLE, 32'h1);
		wake_lvl <= 8'h04;
		apb(1, OFS_POWER_CONTROL, 32'h1);
		wait_mode(MODE_STOP);
		chk({vec[11:8], vec[3], vec[0]}, 6'h03);
		wake_lvl <= 8'h05;
		wait_mode(MODE_DIRECT);
		apb(0, OFS_POWER_CONTROL, 32'h0);
		chk(rd, 32'h0);
		apb(0, OFS_START_RAW, 32'h0);
		chk(rd, 32'h5);
		apb(0, OFS_START_STATUS, 32'h0);
		chk(rd, 32'h1);
		apb(0, OFS_MODE_STATUS, 32'h0);
		chk(rd, 32'h71);
		apb(1, OFS_START_RAW, 32'h5);
		apb(0, OFS_START_RAW, 32'h0);
		chk(rd, 32'h0);
		// Falling edge on source 0 just before the stop request
		apb(1, OFS_START_POLARITY, 32'h1);
		wake_lvl <= 8'h04;
		repeat (4) @(posedge pclk);
		apb(1, OFS_POWER_CONTROL, 32'h1);
		repeat (8) begin
			@(posedge pclk);
			chk(op_mode, MODE_DIRECT);
		end
		apb(0, OFS_POWER_CONTROL, 32'h0);
		chk(rd, 32'h1);
		apb(1, OFS_START_RAW, 32'h1);
		apb(1, OFS_POWER_CONTROL, 32'h0);
		apb(1, OFS_CLK_SOURCE, 32'hF);
		settle;
		chk(system_base_src_rtc, 1'b1);
		finish_test;
	end

	initial begin
		#200000;
		n_mismatch++;
		finish_test;
	end
endmodule
